/* File: hdl/pm_irq_and_reset_cause.sv */
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ns
// Contract
// R1 - Enable-set register at 0x35, resets 0x00, writes blocked when protected.
// R2 - Enable-set bit 0 written one sets clock-ready enable; zero keeps it.
// R3 - Clock-failure enable bit 1 gates its flag onto the interrupt request.
// R4 - Clock-ready flag sets when clocks reach selected ratios; requests if enabled.
// R5 - Writing one clears clock-ready flag; writing zero has no effect.
// R6 - Reset-cause at 0x38 read-only, resets 0x01, bits 7 and 3 unused.
// R7 - Reset-cause bit 6 marks a software reset request.
// R8 - Reset-cause bit 5 marks a watchdog reset.
// R9 - Reset-cause bit 4 marks a reset from the reset pin.
// R10 - Reset-cause bit 2 marks an I/O-supply brown-out reset.
// R11 - Reset-cause bit 1 marks a core-supply brown-out reset.
// R12 - Reset-cause bit 0 marks a power-on reset.
// R13 - Enable-clear at 0x34: one clears enable and request, zero nothing.
// R14 - Interrupt is OR of flag AND enable, held until either clears.
// R15 - Each reset clears the cause and sets only that reset's bit.
// R16 - Clock-failure flag bit 1 sets on failure, write one clears it.
module pm_irq_and_reset_cause (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// AHB-Lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	// Clock events, one-cycle pulses
	input wire logic clock_ready_in,
	input wire logic clock_failure_detect_in,
	// Write protection from the access controller
	input wire logic write_protect_in,
	// Latched reset sources
	input wire pm_irq_pkg::reset_sources_s reset_sources_in,
	// Interrupt request
	output logic irq_out
);
	import pm_irq_pkg::*;

	bus_state_e state_reg;
	bus_state_e state_next;
	bus_cmd_s cmd_reg;
	bus_cmd_s cmd_next;
	logic hready_reg;
	logic hready_next;
	logic hresp_reg;
	logic hresp_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [IRQ_BITS-1:0] en_reg;
	logic [IRQ_BITS-1:0] en_next;
	logic [IRQ_BITS-1:0] flags_reg;
	logic [IRQ_BITS-1:0] flags_next;
	logic [IRQ_BITS-1:0] events;
	logic irq_reg;
	logic irq_next;
	logic [7:0] cause;
	logic [7:0] wdata_byte;
	logic wr_go;

	// True when a byte address is word aligned and hits a mapped register
	function automatic logic is_mapped(logic [31:0] a);
		logic [7:0] i;
		i = a[9:2];
		return (a[31:10] == 22'h000000) && (a[1:0] == 2'h0) &&
			((i == IDX_ENABLE_CLEAR) || (i == IDX_ENABLE_SET) ||
			(i == IDX_FLAGS) || (i == IDX_CAUSE));
	endfunction : is_mapped

	// Accepted command hits a given register
	function automatic logic hits(bus_cmd_s c, logic [7:0] idx);
		return c.mapped && (c.idx == idx);
	endfunction : hits

	// Cause register, captured after each reset
	reset_source_capture cause_capture (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.sources_in(reset_sources_in),
		.cause_out(cause)
	);

	// Write data are taken in the wait cycle of the data phase
	assign wdata_byte = hwdata_in[7:0];
	assign wr_go = (state_reg == BUS_WAIT) && cmd_reg.write && cmd_reg.mapped;
	assign events = {clock_failure_detect_in, clock_ready_in};

	// Bus slave: one wait state, then OKAY with data
	always_comb begin
		state_next = state_reg;
		cmd_next = cmd_reg;
		hready_next = hready_reg;
		rdata_next = rdata_reg;
		// Every transfer answers OKAY
		hresp_next = 1'b0;
		case (state_reg)
			BUS_IDLE: begin
				hready_next = 1'b1;
				if (hsel_in && htrans_in[HTRANS_ACTIVE_BIT] && hready_in) begin
					cmd_next.write = hwrite_in;
					cmd_next.mapped = is_mapped(haddr_in);
					cmd_next.idx = haddr_in[9:2];
					hready_next = 1'b0;
					state_next = BUS_WAIT;
				end
			end
			BUS_WAIT: begin
				hready_next = 1'b1;
				state_next = BUS_IDLE;
				rdata_next = 32'h00000000;
				if (!cmd_reg.write) begin
					// R6 reserved cause bits read as zero
					if (hits(cmd_reg, IDX_CAUSE)) begin
						rdata_next = {24'h000000, cause};
					end else if (hits(cmd_reg, IDX_FLAGS)) begin
						rdata_next = {30'h00000000, flags_reg};
					end else if (hits(cmd_reg, IDX_ENABLE_SET) ||
						hits(cmd_reg, IDX_ENABLE_CLEAR)) begin
						rdata_next = {30'h00000000, en_reg};
					end
				end
			end
			default: begin
				hready_next = 1'b1;
				state_next = BUS_IDLE;
			end
		endcase
	end

	// Bus slave registers
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= BUS_IDLE;
			cmd_reg <= '0;
			hready_reg <= 1'b1;
			rdata_reg <= 32'h00000000;
			hresp_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cmd_reg <= cmd_next;
			hready_reg <= hready_next;
			rdata_reg <= rdata_next;
			hresp_reg <= hresp_next;
		end
	end

	// Enables and flags; hardware set wins over software clear
	always_comb begin
		en_next = en_reg;
		flags_next = flags_reg;
		// R1 protected writes leave the enables alone
		if (wr_go && !write_protect_in) begin
			// R2 write one sets, zero keeps
			if (hits(cmd_reg, IDX_ENABLE_SET)) begin
				en_next = en_reg | wdata_byte[IRQ_BITS-1:0];
			end
			// R13 write one clears enable and its request
			if (hits(cmd_reg, IDX_ENABLE_CLEAR)) begin
				en_next = en_reg & ~wdata_byte[IRQ_BITS-1:0];
			end
		end
		// R5 R16 write one clears a flag, never protected
		if (wr_go && hits(cmd_reg, IDX_FLAGS)) begin
			flags_next = flags_reg & ~wdata_byte[IRQ_BITS-1:0];
		end
		// R4 R16 events set their flags
		flags_next = flags_next | events;
		// R3 R14 request is OR of flag AND enable
		irq_next = |(flags_next & en_next);
	end

	// Enable, flag and request registers
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			en_reg <= ENABLE_RESET;
			flags_reg <= FLAGS_RESET;
			irq_reg <= 1'b0;
		end else begin
			en_reg <= en_next;
			flags_reg <= flags_next;
			irq_reg <= irq_next;
		end
	end

	// Outputs straight from flip-flops
	assign hrdata_out = rdata_reg;
	assign hreadyout_out = hready_reg;
	assign hresp_out = hresp_reg;
	assign irq_out = irq_reg;

	// Assertions share the bus clock and the reset
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	// Committed write of one bit to a register
	sequence wr_bit(logic [7:0] idx, int b, logic v);
		wr_go && hits(cmd_reg, idx) && (wdata_byte[b] == v);
	endsequence

	// Address phase accepted by the idle slave
	sequence addr_taken;
		state_reg == BUS_IDLE && hsel_in && htrans_in[HTRANS_ACTIVE_BIT] &&
			hready_in;
	endsequence

	// Read data phase of a given register
	sequence rd_phase(logic [7:0] idx);
		state_reg == BUS_WAIT && !cmd_reg.write && hits(cmd_reg, idx);
	endsequence

	// Bus protocol checks
	// R6 single wait state
	chk_bus_one_wait: assert property ( // R6
		addr_taken |=> !hreadyout_out ##1 hreadyout_out)
		else $error("bus answer not after one wait state");

	// R6 cause read back
	chk_cause_read_data: assert property ( // R6
		rd_phase(IDX_CAUSE)
		|=> hrdata_out == {24'h000000, $past(cause)} && hrdata_out[7] == 1'b0
		&& hrdata_out[3] == 1'b0)
		else $error("reset cause read wrong");

	// R6 cause ignores writes
	chk_cause_read_only: assert property ( // R6
		wr_go && hits(cmd_reg, IDX_CAUSE) |=> $stable(cause))
		else $error("reset cause changed by a write");

	// R6 unmapped reads zero
	chk_unmapped_read_zero: assert property ( // R6
		state_reg == BUS_WAIT && !cmd_reg.write && !cmd_reg.mapped
		|=> hrdata_out == 32'h00000000)
		else $error("unmapped read not zero");

	// Enable register checks
	// R1 protection holds enables
	chk_protect_enable: assert property ( // R1
		wr_go && write_protect_in |=> $stable(en_reg))
		else $error("protected write changed an enable");

	// R1 enables read back
	chk_enable_read_data: assert property ( // R1
		rd_phase(IDX_ENABLE_SET)
		|=> hrdata_out == {30'h00000000, $past(en_reg)})
		else $error("enable read wrong");

	// R2 one sets enable
	chk_set_ready_en: assert property ( // R2
		wr_bit(IDX_ENABLE_SET, 0, 1'b1) ##0 !write_protect_in
		|=> en_reg[0])
		else $error("enable set of clock ready failed");

	// R2 zero keeps enable
	chk_zero_keeps_en: assert property ( // R2
		wr_bit(IDX_ENABLE_SET, 0, 1'b0) |=> en_reg[0] == $past(en_reg[0]))
		else $error("zero write changed clock ready enable");

	// R3 failure enable set
	chk_set_failure_en: assert property ( // R3
		wr_bit(IDX_ENABLE_SET, 1, 1'b1) ##0 !write_protect_in
		|=> en_reg[1])
		else $error("enable set of clock failure failed");

	// R13 one clears enable
	chk_clear_ready_en: assert property ( // R13
		wr_bit(IDX_ENABLE_CLEAR, 0, 1'b1) ##0 !write_protect_in
		|=> !en_reg[0])
		else $error("enable clear of clock ready failed");

	// R13 zero keeps enable
	chk_clear_zero_keeps: assert property ( // R13
		wr_bit(IDX_ENABLE_CLEAR, 1, 1'b0)
		|=> en_reg[1] == $past(en_reg[1]))
		else $error("zero clear write changed an enable");

	// R13 clear withdraws request
	chk_enable_clear: assert property ( // R13
		wr_bit(IDX_ENABLE_CLEAR, 1, 1'b1) ##0 !write_protect_in
		|=> !en_reg[1] && !(irq_out && !flags_reg[0]))
		else $error("enable clear did not withdraw request");

	// Request and flag checks
	// R3 enabled failure requests
	chk_failure_request: assert property ( // R3
		flags_reg[1] && en_reg[1] |-> irq_out)
		else $error("clock failure request missing");

	// R3 masked flags stay quiet
	chk_no_masked_request: assert property ( // R3
		!(flags_reg[1] && en_reg[1]) && !(flags_reg[0] && en_reg[0])
		|-> !irq_out)
		else $error("request raised without enabled flag");

	// R4 enabled ready requests
	chk_ready_request: assert property ( // R4
		flags_reg[0] && en_reg[0] |-> irq_out)
		else $error("clock ready request missing");

	// R4 ready event sets flag
	chk_ready_flag_set: assert property ( // R4
		clock_ready_in ##0 (en_reg[0] && !wr_go) |=> flags_reg[0] && irq_out)
		else $error("clock ready flag or request missing");

	// R5 one clears flag
	chk_ready_flag_clear: assert property ( // R5
		wr_bit(IDX_FLAGS, 0, 1'b1) ##0 !clock_ready_in
		|=> !flags_reg[0])
		else $error("clock ready flag not cleared");

	// R5 zero keeps flag
	chk_flag_zero_write: assert property ( // R5
		wr_bit(IDX_FLAGS, 0, 1'b0) |=> flags_reg[0] == $past(flags_reg[0])
		|| $past(clock_ready_in))
		else $error("zero write changed clock ready flag");

	// R4 flags read back
	chk_flags_read_data: assert property ( // R4
		rd_phase(IDX_FLAGS)
		|=> hrdata_out == {30'h00000000, $past(flags_reg)})
		else $error("flags read wrong");

	// R14 request holds
	chk_request_holds: assert property ( // R14
		irq_out && !wr_go |=> irq_out)
		else $error("request dropped without a clear");

	// R16 failure sets flag
	chk_failure_flag: assert property ( // R16
		clock_failure_detect_in |=> flags_reg[1])
		else $error("clock failure flag not set");

	// R16 one clears flag
	chk_failure_clear: assert property ( // R16
		wr_bit(IDX_FLAGS, 1, 1'b1) ##0 !clock_failure_detect_in
		|=> !flags_reg[1])
		else $error("clock failure flag not cleared");

	// R16 zero keeps flag
	chk_failure_zero_write: assert property ( // R16
		wr_bit(IDX_FLAGS, 1, 1'b0)
		|=> flags_reg[1] == $past(flags_reg[1])
		|| $past(clock_failure_detect_in))
		else $error("zero write changed clock failure flag");

endmodule : pm_irq_and_reset_cause

/* File: hdl/pm_irq_pkg.sv */
package pm_irq_pkg;

	// Register indexes; byte address is four times the index
	localparam logic [7:0] IDX_ENABLE_CLEAR = 8'h34;
	localparam logic [7:0] IDX_ENABLE_SET = 8'h35;
	localparam logic [7:0] IDX_FLAGS = 8'h36;
	localparam logic [7:0] IDX_CAUSE = 8'h38;

	// Interrupt bit positions (enable and flag registers)
	localparam int BIT_CLOCK_READY = 0;
	localparam int BIT_CLOCK_FAILURE = 1;
	localparam int IRQ_BITS = 2;

	// Reset cause bit positions
	localparam int CAUSE_SOFTWARE = 6;
	localparam int CAUSE_WATCHDOG = 5;
	localparam int CAUSE_PIN = 4;
	localparam int CAUSE_IO_BROWNOUT = 2;
	localparam int CAUSE_CORE_BROWNOUT = 1;
	localparam int CAUSE_POWER_ON = 0;

	// Reset values
	localparam logic [1:0] ENABLE_RESET = 2'h0;
	localparam logic [1:0] FLAGS_RESET = 2'h0;
	localparam logic [7:0] CAUSE_RESET = 8'h01;

	// AHB transfer type bit that marks an active transfer
	localparam int HTRANS_ACTIVE_BIT = 1;

	// Bus slave states, Gray coded
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_WAIT = 2'b01
	} bus_state_e;

	// Accepted address phase
	typedef struct packed {
		logic write;
		logic mapped;
		logic [7:0] idx;
	} bus_cmd_s;

	// Latched sources of the reset just released
	typedef struct packed {
		logic software_reset_request;
		logic watchdog_reset;
		logic pin_reset;
		logic io_supply_brownout;
		logic core_supply_brownout;
		logic power_on;
	} reset_sources_s;

endpackage : pm_irq_pkg

/* File: hdl/reset_source_capture.sv */
`timescale 1ns/1ns
module reset_source_capture (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Reset sources held by the reset controller
	input wire pm_irq_pkg::reset_sources_s sources_in,
	// Captured cause
	output logic [7:0] cause_out
);
	import pm_irq_pkg::*;

	logic pending_reg;
	logic pending_next;
	logic [7:0] cause_reg;
	logic [7:0] cause_next;

	// One-hot cause, power-on first when several are latched
	function automatic logic [7:0] pick_cause(reset_sources_s s);
		logic [7:0] c;
		c = 8'h00;
		if (s.power_on) begin
			c[CAUSE_POWER_ON] = 1'b1;
		end else if (s.core_supply_brownout) begin
			c[CAUSE_CORE_BROWNOUT] = 1'b1;
		end else if (s.io_supply_brownout) begin
			c[CAUSE_IO_BROWNOUT] = 1'b1;
		end else if (s.pin_reset) begin
			c[CAUSE_PIN] = 1'b1;
		end else if (s.watchdog_reset) begin
			c[CAUSE_WATCHDOG] = 1'b1;
		end else if (s.software_reset_request) begin
			c[CAUSE_SOFTWARE] = 1'b1;
		end
		return c;
	endfunction : pick_cause

	// R15 first edge after release replaces the whole cause
	always_comb begin
		pending_next = 1'b0;
		cause_next = cause_reg;
		// R7 R8 R9 R10 R11 R12 one bit per source
		if (pending_reg && (sources_in != '0)) begin
			cause_next = pick_cause(sources_in);
		end
	end

	// Capture registers; reset loads the power-on value
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pending_reg <= 1'b1;
			cause_reg <= CAUSE_RESET;
		end else begin
			pending_reg <= pending_next;
			cause_reg <= cause_next;
		end
	end

	assign cause_out = cause_reg;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	sequence capture_of(int b);
		pending_reg && $onehot(sources_in) && sources_in[b];
	endsequence

	// R15 single cause bit
	chk_cause_single_bit: assert property ($onehot(cause_reg)) // R15
		else $error("reset cause not one-hot");
	// R12 power-on cause
	chk_cause_power_on: assert property ( // R12
		pending_reg && sources_in.power_on |=> cause_reg == CAUSE_RESET)
		else $error("power-on cause missing");
	// R7 software cause
	chk_cause_software: assert property ( // R7
		capture_of(5) |=> cause_reg == 8'h40)
		else $error("software reset cause wrong");
	// R8 watchdog cause
	chk_cause_watchdog: assert property ( // R8
		capture_of(4) |=> cause_reg == 8'h20)
		else $error("watchdog cause wrong");
	// R9 pin cause
	chk_cause_pin: assert property ( // R9
		capture_of(3) |=> cause_reg == 8'h10)
		else $error("pin reset cause wrong");
	// R10 io brownout cause
	chk_cause_io_brownout: assert property ( // R10
		capture_of(2) |=> cause_reg == 8'h04)
		else $error("io brownout cause wrong");
	// R11 core brownout cause
	chk_cause_core_brownout: assert property ( // R11
		capture_of(1) |=> cause_reg == 8'h02)
		else $error("core brownout cause wrong");
	// R15 cause held afterwards
	chk_cause_held: assert property ( // R15
		!pending_reg |=> $stable(cause_reg))
		else $error("reset cause changed after capture");

endmodule : reset_source_capture

/* File: sim/tb.sv */
`timescale 1ns/1ns
module tb;
	import pm_irq_pkg::*;

	logic clk_in, rst_in, hsel_in, hwrite_in, hresp_out, irq_out;
	logic [31:0] haddr_in, hwdata_in, hrdata_out, q;
	logic [1:0] htrans_in;
	logic [2:0] hsize_in;
	logic hreadyout_out, clock_ready_in, clock_failure_detect_in;
	logic write_protect_in;
	reset_sources_s reset_sources_in;
	int errors, total_checks;
	int cause_bit[6];
	localparam logic [31:0] A_CLR = {22'h0, IDX_ENABLE_CLEAR, 2'b00};
	localparam logic [31:0] A_SET = {22'h0, IDX_ENABLE_SET, 2'b00};
	localparam logic [31:0] A_FLG = {22'h0, IDX_FLAGS, 2'b00};
	localparam logic [31:0] A_CAU = {22'h0, IDX_CAUSE, 2'b00};

	pm_irq_and_reset_cause dut (.clk_in(clk_in), .rst_in(rst_in),
		.hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
		.hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
		.hready_in(hreadyout_out), .hrdata_out(hrdata_out),
		.hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
		.clock_ready_in(clock_ready_in),
		.clock_failure_detect_in(clock_failure_detect_in),
		.write_protect_in(write_protect_in),
		.reset_sources_in(reset_sources_in), .irq_out(irq_out));

	// Clock, 100 ns period
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	task automatic conclude;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude

	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// Waits for hready high at a rising edge, bounded
	task automatic wait_ready(output int n);
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (hreadyout_out !== 1'b1 && n < 50);
		if (hreadyout_out !== 1'b1) begin
			errors++;
			conclude();
		end
	endtask : wait_ready

	// One single word transfer; entered just after a rising edge
	task automatic bus(input logic w, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		hsel_in <= 1'b1;
		haddr_in <= a;
		htrans_in <= 2'h2;
		hwrite_in <= w;
		wait_ready(n);
		htrans_in <= 2'h0;
		hwdata_in <= d;
		wait_ready(n);
		r = hrdata_out;
		chk("response", {31'h0, hresp_out}, 32'h0);
		chk("wait states", n, 32'h2);
	endtask : bus

	task automatic chk_irq(input logic exp);
		@(posedge clk_in);
		chk("irq", {31'h0, irq_out}, {31'h0, exp});
	endtask : chk_irq

	// One-cycle clock event pulse
	task automatic event_pulse(input logic fail);
		if (fail) begin
			clock_failure_detect_in <= 1'b1;
		end else begin
			clock_ready_in <= 1'b1;
		end
		@(posedge clk_in);
		clock_failure_detect_in <= 1'b0;
		clock_ready_in <= 1'b0;
		@(posedge clk_in);
	endtask : event_pulse

	task automatic do_reset(input logic [5:0] src);
		rst_in <= 1'b1;
		reset_sources_in <= reset_sources_s'(src);
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (2) @(posedge clk_in);
	endtask : do_reset

	task automatic test_reset_values;
		bus(1'b0, A_SET, 32'h0, q);
		chk("enable reset", q, 32'h0);
		bus(1'b0, A_FLG, 32'h0, q);
		chk("flags reset", q, 32'h0);
		bus(1'b0, A_CAU, 32'h0, q);
		chk("cause reset", q, 32'h01);
		bus(1'b1, 32'h000000DC, 32'hFF, q);
		bus(1'b0, 32'h000000DC, 32'h0, q);
		chk("unmapped", q, 32'h0);
	endtask : test_reset_values

	task automatic test_enables;
		bus(1'b1, A_SET, 32'h01, q);
		bus(1'b0, A_SET, 32'h0, q);
		chk("set bit0", q, 32'h01);
		write_protect_in <= 1'b1;
		bus(1'b1, A_SET, 32'h02, q);
		bus(1'b1, A_CLR, 32'h01, q);
		write_protect_in <= 1'b0;
		bus(1'b0, A_SET, 32'h0, q);
		chk("protected", q, 32'h01);
		bus(1'b1, A_SET, 32'h0, q);
		bus(1'b1, A_CLR, 32'h0, q);
		bus(1'b0, A_CLR, 32'h0, q);
		chk("zero writes", q, 32'h01);
		bus(1'b1, A_CLR, 32'h01, q);
		bus(1'b0, A_SET, 32'h0, q);
		chk("clear bit0", q, 32'h0);
	endtask : test_enables

	task automatic test_clock_ready;
		bus(1'b1, A_SET, 32'h01, q);
		event_pulse(1'b0);
		chk_irq(1'b1);
		bus(1'b1, A_FLG, 32'h0, q);
		bus(1'b0, A_FLG, 32'h0, q);
		chk("ready flag", q, 32'h01);
		chk_irq(1'b1);
		write_protect_in <= 1'b1;
		bus(1'b1, A_FLG, 32'h01, q);
		write_protect_in <= 1'b0;
		chk_irq(1'b0);
		bus(1'b0, A_FLG, 32'h0, q);
		chk("ready cleared", q, 32'h0);
		bus(1'b1, A_CLR, 32'h01, q);
	endtask : test_clock_ready

	task automatic test_clock_failure;
		event_pulse(1'b1);
		chk_irq(1'b0);
		bus(1'b0, A_FLG, 32'h0, q);
		chk("fail flag", q, 32'h02);
		// Clear write and new failure at one edge: the set wins
		fork
			bus(1'b1, A_FLG, 32'h02, q);
			begin
				@(posedge clk_in);
				clock_failure_detect_in <= 1'b1;
				@(posedge clk_in);
				clock_failure_detect_in <= 1'b0;
			end
		join
		bus(1'b0, A_FLG, 32'h0, q);
		chk("set wins", q, 32'h02);
		bus(1'b1, A_SET, 32'h02, q);
		chk_irq(1'b1);
		bus(1'b1, A_CLR, 32'h02, q);
		chk_irq(1'b0);
		bus(1'b1, A_FLG, 32'h02, q);
		bus(1'b0, A_FLG, 32'h0, q);
		chk("fail cleared", q, 32'h0);
	endtask : test_clock_failure

	task automatic test_cause;
		cause_bit = '{CAUSE_POWER_ON, CAUSE_CORE_BROWNOUT, CAUSE_IO_BROWNOUT,
			CAUSE_PIN, CAUSE_WATCHDOG, CAUSE_SOFTWARE};
		for (int k = 0; k < 6; k++) begin
			do_reset(6'h01 << k);
			bus(1'b1, A_CAU, 32'hFF, q);
			bus(1'b0, A_CAU, 32'h0, q);
			chk("cause", q, 32'h1 << cause_bit[k]);
		end
		do_reset(6'h18);
		bus(1'b0, A_CAU, 32'h0, q);
		chk("one cause", q, 32'h1 << CAUSE_PIN);
	endtask : test_cause

	// Main sequence
	initial begin
		errors = 0;
		total_checks = 0;
		rst_in = 1'b1;
		hsel_in = 1'b0;
		haddr_in = 32'h0;
		htrans_in = 2'h0;
		hwrite_in = 1'b0;
		hsize_in = 3'h2;
		hwdata_in = 32'h0;
		clock_ready_in = 1'b0;
		clock_failure_detect_in = 1'b0;
		write_protect_in = 1'b0;
		reset_sources_in = reset_sources_s'(6'h01);
		do_reset(6'h01);
		test_reset_values();
		test_enables();
		test_clock_ready();
		test_clock_failure();
		test_cause();
		conclude();
	end
endmodule : tb
